// ### inc/ptr_pkg.sv
package ptr_pkg;

	// Bus shape and instance counts
	localparam int PTR_AW = 4;
	localparam int PTR_DW = 16;
	localparam int PTR_NUM_CCP = 5;
	localparam int PTR_NUM_DAC = 2;

	// Register offsets (word index on the plain port)
	localparam logic [3:0] PTR_OFF_CCP_BASE = 4'h0;
	localparam logic [3:0] PTR_OFF_METER_CTL = 4'h5;
	localparam logic [3:0] PTR_OFF_SW_DISCH = 4'h6;
	localparam logic [3:0] PTR_OFF_DAC_BASE = 4'h7;
	localparam logic [3:0] PTR_OFF_STATUS = 4'h9;

	// Capture/compare routing register fields
	localparam int PTR_CCP_AUX_LSB = 0;
	localparam int PTR_CCP_CAPTURE_COMPARE_SELECT_BIT = 2;
	localparam int PTR_CCP_MODE_LSB = 3;
	localparam int PTR_CCP_CAPDIS_BIT = 7;

	// Meter control fields
	localparam int PTR_MTR_DISCH_LSB = 0;
	localparam int PTR_MTR_SRCRST_BIT = 4;
	localparam int PTR_SWD_BIT = 0;

	// DAC control fields
	localparam int PTR_DAC_REF_LSB = 0;
	localparam int PTR_DAC_TRIG_LSB = 2;

	// Reset values
	localparam logic [7:0] PTR_RST_CCP = 8'h00;
	localparam logic [2:0] PTR_RST_DISCH = 3'h0;
	localparam logic [6:0] PTR_RST_DAC = 7'h00;

	// Aux select codes and time base mode
	localparam logic [1:0] PTR_AUX_OFF = 2'h0;
	localparam logic [1:0] PTR_AUX_ROLL = 2'h1;
	localparam logic [1:0] PTR_AUX_SEL2 = 2'h2;
	localparam logic [1:0] PTR_AUX_SEL3 = 2'h3;
	localparam logic [3:0] PTR_MODE_TBASE = 4'h0;

	// Discharge source codes
	localparam logic [2:0] PTR_DIS_NONE = 3'h0;
	localparam logic [2:0] PTR_DIS_CCP1 = 3'h1;
	localparam logic [2:0] PTR_DIS_CCP5 = 3'h3;
	localparam logic [2:0] PTR_DIS_ADC = 3'h4;
	localparam logic [2:0] PTR_DIS_RSVD = 3'h5;
	localparam logic [2:0] PTR_DIS_LOGIC_CELL_ONE = 3'h6;
	localparam logic [2:0] PTR_DIS_LOGIC_CELL_TWO = 3'h7;

	// DAC trigger codes
	localparam logic [4:0] PTR_DT_CCP1 = 5'h01;
	localparam logic [4:0] PTR_DT_CCP5 = 5'h05;
	localparam logic [4:0] PTR_DT_EXT0 = 5'h08;
	localparam logic [4:0] PTR_DT_EXT2 = 5'h0a;
	localparam logic [4:0] PTR_DT_TMR1 = 5'h0b;
	localparam logic [4:0] PTR_DT_LOGIC_CELL_ONE = 5'h11;
	localparam logic [4:0] PTR_DT_LOGIC_CELL_TWO = 5'h12;
	localparam logic [4:0] PTR_DT_CMP1 = 5'h18;
	localparam logic [4:0] PTR_DT_CMP3 = 5'h1a;
	localparam logic [4:0] PTR_DT_ADC = 5'h1b;
	localparam logic [4:0] PTR_DT_METER = 5'h1c;

	// DAC reference codes
	localparam logic [1:0] PTR_REF_NONE = 2'h0;
	localparam logic [1:0] PTR_REF_PIN = 2'h1;
	localparam logic [1:0] PTR_REF_AVDD = 2'h2;
	localparam logic [1:0] PTR_REF_BGAP = 2'h3;

endpackage

// ### core/ptr_aux_sel.sv
`timescale 1ns/1ps
// Auxiliary output selector of one capture/compare module
module ptr_aux_sel
	import ptr_pkg::*;
(
	// Configuration
	input wire logic [1:0] i_aux_sel,
	input wire logic i_capture_compare_select,
	input wire logic [3:0] i_mode,
	input wire logic i_capdis,
	// Module signals
	input wire logic i_roll,
	input wire logic i_special,
	input wire logic i_cmp_evt,
	input wire logic i_cmp_out,
	input wire logic i_cap_evt,
	// Result
	output logic o_aux
);

	// Select by aux code, then by operating family
	always_comb
	begin
		o_aux = 1'b0;
		case (i_aux_sel)
			PTR_AUX_ROLL: o_aux = i_roll;
			PTR_AUX_SEL2:
			begin
				if (i_capture_compare_select)
					o_aux = i_capdis;
				else if (i_mode == PTR_MODE_TBASE)
					o_aux = i_special;
				else
					o_aux = i_cmp_evt;
			end
			PTR_AUX_SEL3:
			begin
				if (i_capture_compare_select)
					o_aux = i_cap_evt;
				else if (i_mode != PTR_MODE_TBASE)
					o_aux = i_cmp_out;
				else
					o_aux = 1'b0;
			end
			default: o_aux = 1'b0;
		endcase
	end

endmodule // ptr_aux_sel

// ### core/ptr_dac_trig.sv
`timescale 1ns/1ps
// Trigger source selector of one DAC
module ptr_dac_trig
	import ptr_pkg::*;
(
	// Selection
	input wire logic [4:0] i_sel,
	// Candidate sources
	input wire logic [4:0] i_ccp_sync,
	input wire logic [2:0] i_ext_int,
	input wire logic i_tmr1_sync,
	input wire logic i_logic_cell_one,
	input wire logic i_logic_cell_two,
	input wire logic [2:0] i_cmp,
	input wire logic i_adc,
	input wire logic i_meter,
	// Result
	output logic o_trig
);

	// Ranges are decoded by offset from the first code of a group
	always_comb
	begin
		o_trig = 1'b0;
		if (i_sel >= PTR_DT_CCP1 && i_sel <= PTR_DT_CCP5)
			o_trig = i_ccp_sync[3'(i_sel - PTR_DT_CCP1)];
		else if (i_sel >= PTR_DT_EXT0 && i_sel <= PTR_DT_EXT2)
			o_trig = i_ext_int[2'(i_sel - PTR_DT_EXT0)];
		else if (i_sel >= PTR_DT_CMP1 && i_sel <= PTR_DT_CMP3)
			o_trig = i_cmp[2'(i_sel - PTR_DT_CMP1)];
		else
		begin
			case (i_sel)
				PTR_DT_TMR1: o_trig = i_tmr1_sync;
				PTR_DT_LOGIC_CELL_ONE: o_trig = i_logic_cell_one;
				PTR_DT_LOGIC_CELL_TWO: o_trig = i_logic_cell_two;
				PTR_DT_ADC: o_trig = i_adc;
				PTR_DT_METER: o_trig = i_meter;
				default: o_trig = 1'b0;
			endcase
		end
	end

endmodule // ptr_dac_trig

// ### core/ptr_routing.sv
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Peripheral trigger routing: aux outputs, discharge and DAC triggers
module ptr_routing
	import ptr_pkg::*;
#(
	// Code used for module 2's aux output; printed value is in doubt
	parameter logic [2:0] CCP2_DISCH_CODE = 3'h2
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [ptr_pkg::PTR_AW-1:0] i_addr,
	input wire logic [ptr_pkg::PTR_DW-1:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [ptr_pkg::PTR_DW-1:0] o_rdata,
	// Capture/compare module signals, one bit per module
	input wire logic [4:0] i_ccp_roll,
	input wire logic [4:0] i_ccp_special,
	input wire logic [4:0] i_ccp_cmp_evt,
	input wire logic [4:0] i_ccp_cmp_out,
	input wire logic [4:0] i_ccp_cap_evt,
	input wire logic [4:0] i_ccp_sync,
	// Other trigger sources
	input wire logic i_adc_eoc,
	input wire logic i_logic_cell_one,
	input wire logic i_logic_cell_two,
	input wire logic [2:0] i_cmp,
	input wire logic [2:0] i_ext_int,
	input wire logic i_tmr1_sync,
	input wire logic i_meter_evt,
	// Routed results
	output logic [4:0] o_ccp_aux,
	output logic o_discharge,
	output logic [1:0] o_dac_update,
	output logic [3:0] o_dac_ref,
	output logic [1:0] o_dac_enable
);

	// Whole state of the block
	typedef struct packed {
		logic [4:0][7:0] ccp_cfg; // Per-module routing config
		logic [2:0] disch_sel; // Discharge source code
		logic src_rst_en; // Software discharge resets edges
		logic sw_dis; // Software discharge control
		logic [1:0][6:0] dac_ctl; // Trigger and reference
		logic [1:0] dac_en; // DAC enables, registered like the rest
		logic [4:0] aux; // Registered aux outputs
		logic disch_prev; // Last discharge source level
		logic discharge; // Discharge output
		logic [1:0] dac_prev; // Last DAC trigger levels
		logic [1:0] dac_upd; // DAC update pulses
		logic [7:0] disch_cnt; // Hardware discharges seen
		logic [15:0] rdata; // Read data
	} ptr_state_s;

	ptr_state_s st_reg; // Current state
	ptr_state_s st_next; // Next state

	logic [4:0] aux_comb; // Aux selector results
	logic [1:0] dac_trig; // DAC selector results
	logic disch_src; // Selected discharge source level
	logic disch_hold; // Hardware discharge held off

	// Discharge source decode; aux outputs of modules 1, 2 and 5, A/D and both logic cells route here
	function automatic logic disch_pick(input logic [2:0] sel,
		input logic [4:0] aux, input logic adc, input logic c1,
		input logic c2);
		logic r;
		r = 1'b0;
		if (sel == CCP2_DISCH_CODE && sel != PTR_DIS_NONE)
			r = aux[1];
		else
		begin
			case (sel)
				PTR_DIS_CCP1: r = aux[0];
				PTR_DIS_CCP5: r = aux[4];
				PTR_DIS_ADC: r = adc;
				PTR_DIS_LOGIC_CELL_ONE: r = c1;
				PTR_DIS_LOGIC_CELL_TWO: r = c2;
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	// Register read decode, unmapped reads give zero
	function automatic logic [15:0] reg_read(input logic [3:0] a,
		input ptr_state_s s);
		logic [15:0] d;
		d = 16'h0000;
		if (a < PTR_OFF_METER_CTL)
			d = {8'h00, s.ccp_cfg[3'(a - PTR_OFF_CCP_BASE)]};
		else if (a == PTR_OFF_METER_CTL)
		begin
			d[PTR_MTR_SRCRST_BIT] = s.src_rst_en;
			d[PTR_MTR_DISCH_LSB +: 3] = s.disch_sel;
		end
		else if (a == PTR_OFF_SW_DISCH)
			d[PTR_SWD_BIT] = s.sw_dis;
		else if (a >= PTR_OFF_DAC_BASE && a < PTR_OFF_STATUS)
			d = {9'h000, s.dac_ctl[1'(a - PTR_OFF_DAC_BASE)]};
		else if (a == PTR_OFF_STATUS)
			d = {s.disch_cnt, s.dac_upd, s.discharge, s.aux};
		return d;
	endfunction

	// One aux selector per capture/compare module
	for (genvar g = 0; g < PTR_NUM_CCP; g++)
	begin : g_aux
		ptr_aux_sel u_aux (
			.i_aux_sel(st_reg.ccp_cfg[g][PTR_CCP_AUX_LSB +: 2]),
			.i_capture_compare_select(st_reg.ccp_cfg[g][PTR_CCP_CAPTURE_COMPARE_SELECT_BIT]),
			.i_mode(st_reg.ccp_cfg[g][PTR_CCP_MODE_LSB +: 4]),
			.i_capdis(st_reg.ccp_cfg[g][PTR_CCP_CAPDIS_BIT]),
			.i_roll(i_ccp_roll[g]),
			.i_special(i_ccp_special[g]),
			.i_cmp_evt(i_ccp_cmp_evt[g]),
			.i_cmp_out(i_ccp_cmp_out[g]),
			.i_cap_evt(i_ccp_cap_evt[g]),
			.o_aux(aux_comb[g])
		);
	end

	// One trigger selector per DAC
	for (genvar d = 0; d < PTR_NUM_DAC; d++)
	begin : g_dac
		ptr_dac_trig u_trig (
			.i_sel(st_reg.dac_ctl[d][PTR_DAC_TRIG_LSB +: 5]),
			.i_ccp_sync(i_ccp_sync),
			.i_ext_int(i_ext_int),
			.i_tmr1_sync(i_tmr1_sync),
			.i_logic_cell_one(i_logic_cell_one),
			.i_logic_cell_two(i_logic_cell_two),
			.i_cmp(i_cmp),
			.i_adc(i_adc_eoc),
			.i_meter(i_meter_evt),
			.o_trig(dac_trig[d])
		);
	end

	// Discharge source uses the registered aux, one cycle behind
	always_comb
	begin
		disch_src = disch_pick(st_reg.disch_sel, st_reg.aux,
			i_adc_eoc, i_logic_cell_one, i_logic_cell_two);
		disch_hold = st_reg.src_rst_en && st_reg.sw_dis;
	end

	// Next state: register writes, routing and edge detection
	always_comb
	begin
		st_next = st_reg;
		// Software writes
		if (i_we)
		begin
			if (i_addr < PTR_OFF_METER_CTL)
				st_next.ccp_cfg[3'(i_addr - PTR_OFF_CCP_BASE)] =
					i_wdata[7:0];
			else if (i_addr == PTR_OFF_METER_CTL)
			begin
				st_next.disch_sel = i_wdata[PTR_MTR_DISCH_LSB +: 3];
				st_next.src_rst_en = i_wdata[PTR_MTR_SRCRST_BIT];
			end
			else if (i_addr == PTR_OFF_SW_DISCH)
				st_next.sw_dis = i_wdata[PTR_SWD_BIT];
			else if (i_addr >= PTR_OFF_DAC_BASE &&
				i_addr < PTR_OFF_STATUS)
				st_next.dac_ctl[1'(i_addr - PTR_OFF_DAC_BASE)] =
					i_wdata[6:0];
		end
		// Enables track the new reference code, so they move with o_dac_ref
		for (int k = 0; k < PTR_NUM_DAC; k++)
			st_next.dac_en[k] =
				st_next.dac_ctl[k][PTR_DAC_REF_LSB +: 2] != PTR_REF_NONE;
		// Aux outputs registered so every top output is a flop
		st_next.aux = aux_comb;
		// Discharge: software level alone, or one pulse per edge
		if (st_reg.disch_sel == PTR_DIS_NONE)
		begin
			st_next.discharge = st_reg.sw_dis;
			st_next.disch_prev = 1'b0;
		end
		else if (disch_hold)
		begin
			// Edge logic held in reset while software discharges
			st_next.discharge = 1'b0;
			st_next.disch_prev = disch_src;
		end
		else
		begin
			st_next.discharge = disch_src && !st_reg.disch_prev;
			st_next.disch_prev = disch_src;
		end
		if (st_next.discharge && !st_reg.discharge &&
			st_reg.disch_sel != PTR_DIS_NONE)
			st_next.disch_cnt = st_reg.disch_cnt + 8'h01;
		// DAC: one update per rising edge of the selected trigger
		for (int k = 0; k < PTR_NUM_DAC; k++)
		begin
			st_next.dac_upd[k] = dac_trig[k] && !st_reg.dac_prev[k] &&
				(st_reg.dac_ctl[k][PTR_DAC_REF_LSB +: 2] !=
				PTR_REF_NONE);
			st_next.dac_prev[k] = dac_trig[k];
		end
		// Read data valid the cycle after the strobe only
		st_next.rdata = i_re ? reg_read(i_addr, st_reg) : 16'h0000;
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			st_reg <= '0;
			for (int k = 0; k < PTR_NUM_CCP; k++)
				st_reg.ccp_cfg[k] <= PTR_RST_CCP;
			st_reg.disch_sel <= PTR_RST_DISCH;
			for (int k = 0; k < PTR_NUM_DAC; k++)
			begin
				st_reg.dac_ctl[k] <= PTR_RST_DAC;
				st_reg.dac_en[k] <= PTR_RST_DAC[1:0] != PTR_REF_NONE;
			end
		end
		else
			st_reg <= st_next;
	end

	// Outputs straight from flops; reference decode is registered
	assign o_rdata = st_reg.rdata;
	assign o_ccp_aux = st_reg.aux;
	assign o_discharge = st_reg.discharge;
	assign o_dac_update = st_reg.dac_upd;
	assign o_dac_ref = {st_reg.dac_ctl[1][1:0], st_reg.dac_ctl[0][1:0]};
	assign o_dac_enable = st_reg.dac_en;

	// Checks on module 1, the discharge output and DAC 0
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	aux_off_a: assert property (
		st_reg.ccp_cfg[0][1:0] == PTR_AUX_OFF |=> !o_ccp_aux[0])
		else $error("aux output not off for select 00");
	aux_roll_a: assert property (
		st_reg.ccp_cfg[0][1:0] == PTR_AUX_ROLL |=>
		o_ccp_aux[0] == $past(i_ccp_roll[0]))
		else $error("aux output does not follow rollover");
	aux_special_a: assert property (
		st_reg.ccp_cfg[0][1:0] == PTR_AUX_SEL2 &&
		!st_reg.ccp_cfg[0][2] && st_reg.ccp_cfg[0][6:3] == 4'h0 |=>
		o_ccp_aux[0] == $past(i_ccp_special[0]))
		else $error("time base aux 10 not special event");
	aux_cmpout_a: assert property (
		st_reg.ccp_cfg[0][1:0] == PTR_AUX_SEL3 &&
		!st_reg.ccp_cfg[0][2] && st_reg.ccp_cfg[0][6:3] != 4'h0 |=>
		o_ccp_aux[0] == $past(i_ccp_cmp_out[0]))
		else $error("compare aux 11 not compare output");
	aux_capdis_a: assert property (
		st_reg.ccp_cfg[0][2:0] == 3'h6 |=>
		o_ccp_aux[0] == $past(st_reg.ccp_cfg[0][7]))
		else $error("capture aux 10 not disable bit");
	disch_adc_a: assert property (
		st_reg.disch_sel == PTR_DIS_ADC && !disch_hold &&
		i_adc_eoc && !st_reg.disch_prev |=> o_discharge ##1
		(!o_discharge || $past(!st_reg.disch_prev)))
		else $error("A/D end of conversion gave no discharge");
	disch_sw_a: assert property (
		st_reg.disch_sel == PTR_DIS_NONE |=>
		o_discharge == $past(st_reg.sw_dis))
		else $error("discharge not following software bit");
	dac_unused_a: assert property (
		st_reg.dac_ctl[0][6:2] == 5'h00 ||
		st_reg.dac_ctl[0][6:2] == 5'h1f |=> !o_dac_update[0])
		else $error("unused DAC trigger code caused update");
	dac_noref_a: assert property (
		st_reg.dac_ctl[0][1:0] == PTR_REF_NONE |->
		!o_dac_enable[0] ##1 !o_dac_update[0])
		else $error("DAC active without reference");
	dac_single_a: assert property (
		o_dac_update[0] |=> !o_dac_update[0])
		else $error("DAC update longer than one cycle");

	// Hardware sources seen through the selectors, module 5 and DAC 0
	disch_ccp5_a: assert property (
		st_reg.disch_sel == PTR_DIS_CCP5 && !disch_hold &&
		st_reg.aux[4] && !st_reg.disch_prev |=> o_discharge)
		else $error("module 5 aux output gave no discharge");

	disch_pulse_a: assert property (
		o_discharge && st_reg.disch_sel != PTR_DIS_NONE &&
		$past(st_reg.disch_sel) != PTR_DIS_NONE |=> !o_discharge)
		else $error("hardware discharge longer than one cycle");

	dac_adc_a: assert property (
		st_reg.dac_ctl[0][6:2] == PTR_DT_ADC && o_dac_enable[0] &&
		i_adc_eoc && !st_reg.dac_prev[0] |=> o_dac_update[0])
		else $error("A/D trigger gave no DAC update");

	dac_sync_a: assert property (
		st_reg.dac_ctl[0][6:2] == PTR_DT_CCP5 && o_dac_enable[0] &&
		i_ccp_sync[4] && !st_reg.dac_prev[0] |=> o_dac_update[0])
		else $error("module 5 sync gave no DAC update");

	dac_ext_a: assert property (
		st_reg.dac_ctl[0][6:2] == PTR_DT_EXT0 && o_dac_enable[0] &&
		i_ext_int[0] && !st_reg.dac_prev[0] |=> o_dac_update[0])
		else $error("external line 0 gave no DAC update");

	dac_clc_a: assert property (
		st_reg.dac_ctl[0][6:2] == PTR_DT_LOGIC_CELL_TWO && o_dac_enable[0] &&
		i_logic_cell_two && !st_reg.dac_prev[0] |=> o_dac_update[0])
		else $error("logic cell 2 gave no DAC update");

endmodule // ptr_routing

// ### tb/ptr_src_model.sv
`timescale 1ns/1ps
// Peripherals that raise the trigger lines seen by the router
module ptr_src_model
(
	// Clock
	input wire logic i_clk,
	// Bench requests, one bit per source line
	input wire logic [40:0] i_req,
	// Slow mode: one extra cycle before a request shows
	input wire logic i_slow,
	// Source lines
	output logic [40:0] o_src
);
	// Delay stage used only in slow mode
	logic [40:0] hold_reg;

	// Registered like a peripheral's own output flop
	always_ff @(posedge i_clk)
	begin
		hold_reg <= i_req;
		o_src <= i_slow ? hold_reg : i_req;
	end
endmodule // ptr_src_model

// ### tb/test_ptr_routing.sv
`timescale 1ns/1ps
// Self-checking bench for the trigger router
module test_ptr_routing;
	import ptr_pkg::*;
	// Bit positions in the source vector
	localparam int SPEC = 5, CEV = 10, COUT = 15, CAP = 20, SYNC = 25;
	localparam int ADC = 30, LOGIC_CELL_ONE = 31, LOGIC_CELL_TWO = 32, CMP = 33, EXT = 36;
	localparam int TMR = 39, MTR = 40;
	logic clk = 0;
	logic rst_n = 0;
	logic [3:0] addr = 0;
	logic [15:0] wdata = 0;
	logic we = 0;
	logic re = 0;
	logic [40:0] req = 0;
	logic slow = 0;
	logic [40:0] src;
	logic [15:0] rdata;
	logic [4:0] aux;
	logic disch;
	logic [1:0] upd;
	logic [3:0] dref;
	logic [1:0] den;
	int n_mismatch = 0;
	int cmp_count = 0;
	int dsel = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	ptr_src_model srcs (.i_clk(clk), .i_req(req), .i_slow(slow), .o_src(src));

	ptr_routing #(.CCP2_DISCH_CODE(3'h2)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_we(we), .i_re(re), .o_rdata(rdata),
		.i_ccp_roll(src[4:0]), .i_ccp_special(src[9:5]),
		.i_ccp_cmp_evt(src[14:10]), .i_ccp_cmp_out(src[19:15]),
		.i_ccp_cap_evt(src[24:20]), .i_ccp_sync(src[29:25]),
		.i_adc_eoc(src[30]), .i_logic_cell_one(src[31]), .i_logic_cell_two(src[32]),
		.i_cmp(src[35:33]), .i_ext_int(src[38:36]),
		.i_tmr1_sync(src[39]), .i_meter_evt(src[40]),
		.o_ccp_aux(aux), .o_discharge(disch), .o_dac_update(upd),
		.o_dac_ref(dref), .o_dac_enable(den));

	// Expected aux output; v is {cap, cmp out, cmp evt, special, roll}
	function automatic logic aux_exp(logic [7:0] c, logic [4:0] v);
		if (c[1:0] == 2'h0) return 1'b0;
		if (c[1:0] == 2'h1) return v[0];
		if (c[2]) return (c[1:0] == 2'h2) ? c[7] : v[4];
		if (c[6:3] == 4'h0) return (c[1:0] == 2'h2) ? v[1] : 1'b0;
		return (c[1:0] == 2'h2) ? v[2] : v[3];
	endfunction

	// Source bit that a discharge code should follow, -1 for none
	function automatic int dis_src(int c);
		case (c)
			1: return 0;
			2: return 1;
			3: return 4;
			4: return ADC;
			6: return LOGIC_CELL_ONE;
			7: return LOGIC_CELL_TWO;
			default: return -1;
		endcase
	endfunction

	// Source bit that a DAC trigger code should follow, -1 for none
	function automatic int dac_src(int c);
		if (c >= 1 && c <= 5) return SYNC + c - 1;
		if (c >= 8 && c <= 10) return EXT + c - 8;
		if (c >= 24 && c <= 26) return CMP + c - 24;
		if (c == 11) return TMR;
		if (c == 17) return LOGIC_CELL_ONE;
		if (c == 18) return LOGIC_CELL_TWO;
		if (c == 27) return ADC;
		if (c == 28) return MTR;
		return -1;
	endfunction

	// Writable bits of each word index; status and holes have none
	function automatic logic [15:0] mask(int a);
		if (a < 5) return 16'h00ff;
		if (a == 5) return 16'h0017;
		if (a == 6) return 16'h0001;
		if (a < 9) return 16'h007f;
		return 16'h0000;
	endfunction

	// Single comparison point
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle write
	task automatic wr(int a, logic [15:0] d);
		@(posedge clk);
		addr <= a[3:0];
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask

	// One-cycle read; data taken in the following cycle only
	task automatic rd(int a, output logic [15:0] d);
		@(posedge clk);
		addr <= a[3:0];
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask

	// Pulse one source line and count discharges and DAC updates
	task automatic trial(int s, output logic [3:0] nd, output logic [3:0] nu);
		@(posedge clk);
		req[s] <= 1'b1;
		@(posedge clk);
		req[s] <= 1'b0;
		nd = 0;
		nu = 0;
		repeat (6)
		begin
			@(posedge clk);
			#1 nd = nd + disch;
			nu = nu + upd[dsel];
		end
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	// Main sequence
	initial
	begin
		logic [15:0] d, r;
		logic [7:0] cfg;
		logic [3:0] nd, nu;
		logic [15:0] e;
		logic [4:0] ax;
		logic [2:0] dc;
		logic sw;
		int k0;
		void'($urandom(87));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, then random write and read back, hole included
		for (int a = 0; a < 11; a++)
		begin
			rd(a, d);
			chk("reset value", d, 16'h0);
		end
		for (int a = 0; a < 11; a++)
		begin
			r = 16'($urandom);
			wr(a, r);
			if (a < 5)
				ax[a] = aux_exp(r[7:0], 5'h00);
			if (a == 5)
				dc = r[2:0];
			if (a == 6)
				sw = r[0];
			rd(a, d);
			// Status: sources idle, so only levels and one edge can show
			k0 = dis_src(dc);
			e = (a == 9) ? {7'h00, k0 >= 0 && k0 < 5 && ax[k0], 2'h0,
				dc == 3'h0 && sw, ax} : r & mask(a);
			chk("read back", d, e);
		end
		$display("register test done");
		// Aux selector across select, capture and mode combinations
		wr(6, 16'h0);
		for (int k = 0; k < 64; k++)
		begin
			r = 16'($urandom);
			cfg = {r[7], k[3] ? r[6:3] : 4'h0, k[2], k[1:0]};
			wr(0, {8'h0, cfg});
			@(posedge clk);
			{req[CAP], req[COUT], req[CEV], req[SPEC], req[0]} <= r[12:8];
			repeat (3) @(posedge clk);
			#1 chk("aux", aux[0], aux_exp(cfg, r[12:8]));
		end
		req <= '0;
		$display("aux test done");
		// Discharge source codes against every candidate source
		for (int a = 0; a < 5; a++) wr(a, 16'h0001);
		for (int c = 1; c < 8; c++)
		begin
			wr(5, c);
			for (int s = 0; s <= LOGIC_CELL_TWO; s++)
			begin
				if (s < 5 || s >= ADC)
				begin
					trial(s, nd, nu);
					chk("discharge", nd, s == dis_src(c));
				end
			end
		end
		// Code zero: only the software bit acts
		wr(5, 16'h0);
		trial(ADC, nd, nu);
		chk("no source", nd, 16'h0);
		wr(6, 16'h1);
		repeat (2) @(posedge clk);
		#1 chk("sw discharge on", disch, 16'h1);
		wr(6, 16'h0);
		repeat (2) @(posedge clk);
		#1 chk("sw discharge off", disch, 16'h0);
		$display("discharge test done");
		// Every DAC trigger code against every candidate, both DACs
		for (int dd = 0; dd < 2; dd++)
		begin
			dsel = dd;
			for (int c = 0; c < 32; c++)
			begin
				wr(7 + dd, {9'h0, c[4:0], 2'h2});
				slow <= c[0];
				for (int s = SYNC; s <= MTR; s++)
				begin
					trial(s, nd, nu);
					chk("dac update", nu, s == dac_src(c));
				end
			end
		end
		// Reference select; code 00 turns the DAC off
		dsel = 0;
		wr(7, 16'h006c);
		trial(ADC, nd, nu);
		chk("dac off", nu, 16'h0);
		for (int k = 0; k < 4; k++)
		begin
			wr(7, k);
			wr(8, k);
			repeat (2) @(posedge clk);
			#1 chk("dac ref", dref, {k[1:0], k[1:0]});
			chk("dac enable", den, {2{k != 0}});
		end
		$display("dac test done");
		final_report();
	end
endmodule // test_ptr_routing
